// ### bench/fcr_chk.sv
// Port checker of the flash controller, bound to its top module
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.vh"
module fcr_chk (
  input wire logic        core_clk_i,
  input wire logic        resetn_i,
  input wire logic        m0_dbg_i,
  input wire logic [31:0] m0_addr_i,
  input wire logic        m0_ack_o,
  input wire logic        m0_abort_o,
  input wire logic [31:0] m1_addr_i,
  input wire logic        m1_ack_o,
  input wire logic        m1_abort_o,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_we_i,
  input wire logic        reg_re_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic        busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  // Keyed command write
  wire key_wr = reg_we_i && reg_addr_i == `FCR_REG_CMD
    && reg_wdata_i[31:24] == `FCR_CMD_KEY;
  // Command taken one or two edges before busy
  sequence key_seen_s;
    $past(key_wr) || $past(key_wr, 2);
  endsequence
  // Busy must last at least eight cycles
  sequence busy_run_s;
    busy_o [*8];
  endsequence
  abort_with_ack_a: assert property (m0_abort_o |-> m0_ack_o)
    else $error("m0 lone abort");
  dma_abort_ack_a: assert property (m1_abort_o |-> m1_ack_o)
    else $error("m1 lone abort");
  hole_abort_a: assert property (m0_ack_o && m0_addr_i[31:20] >= 12'h003 |-> m0_abort_o)
    else $error("m0 hole open");
  dma_hole_abort_a: assert property (m1_ack_o && m1_addr_i[31:20] >= 12'h003 |-> m1_abort_o)
    else $error("m1 hole open");
  flash_open_a: assert property (m0_ack_o && !m0_dbg_i
    && m0_addr_i[31:20] == `FCR_MAP_FLASH |-> !m0_abort_o)
    else $error("flash aborted");
  ack_pulse_a: assert property (m0_ack_o |=> !m0_ack_o)
    else $error("m0 long ack");
  one_grant_a: assert property (!(m0_ack_o && m1_ack_o))
    else $error("double ack");
  busy_cause_a: assert property ($rose(busy_o) |-> key_seen_s)
    else $error("unkeyed busy");
  busy_min_a: assert property ($rose(busy_o) |-> busy_run_s)
    else $error("short busy");
  stat_busy_a: assert property (reg_re_i && reg_addr_i == `FCR_REG_STAT
    |=> reg_rdata_o[`FCR_ST_BUSY] == $past(busy_o))
    else $error("busy bit");
  cmd_zero_a: assert property (reg_re_i && reg_addr_i == `FCR_REG_CMD
    |=> reg_rdata_o == 32'h0)
    else $error("cmd not zero");
endmodule // fcr_chk
bind fcr_flash_ctrl fcr_chk fcr_chk_i (.*);
`default_nettype wire

// ### bench/fcr_master_model.sv
// Bus master model for the processor and DMA sides
`timescale 1ns/1ps
`default_nettype none
module fcr_master_model (
  input  wire logic        core_clk_i,
  input  wire logic        ack_i,
  input  wire logic        abort_i,
  input  wire logic [31:0] rdata_i,
  output var  logic        req_o,
  output var  logic        we_o,
  output var  logic        flag_o,
  output var  logic [31:0] addr_o,
  output var  logic [31:0] wdata_o
);
  // Idle at time zero
  initial
    {req_o, we_o, flag_o, addr_o, wdata_o} = 67'h0;
  // One word after gap idle edges; n counts edges up to the ack
  task automatic xfer(output logic [31:0] q, output logic ab, output int n,
    input logic [31:0] a, input logic f = 1'b0, input int gap = 0,
    input logic w = 1'b0, input logic [31:0] d = 32'h0);
    repeat (gap) @(posedge core_clk_i);
    @(posedge core_clk_i);
    req_o <= 1'b1; // Held with its qualifiers until ack
    we_o <= w;
    flag_o <= f;
    addr_o <= a;
    wdata_o <= d;
    n = 0;
    do
    begin
      @(posedge core_clk_i);
      n++;
    end while (ack_i !== 1'b1 && n < 64);
    q = rdata_i;
    ab = abort_i;
    req_o <= 1'b0;
    // Released lines show no stale value
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
endmodule // fcr_master_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench of the flash controller
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.vh"
module testbench;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic erase_pin_i = 1'b0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0;
  wire m0_req_i, m0_we_i, m0_dbg_i, m0_ack_o, m0_abort_o;
  wire m1_req_i, m1_we_i, m1_fpp_i, m1_ack_o, m1_abort_o, irq_o, busy_o;
  wire [31:0] m0_addr_i, m0_wdata_i, m1_addr_i, m1_wdata_i, bus_rdata_o;
  wire [31:0] reg_rdata_o;
  int mismatches = 0;
  int check_count = 0;
  int cycles = 0;
  logic [31:0] q, d;
  logic ab;
  int n;
  // Shrunk busy and hold times keep the run short
  fcr_flash_ctrl #(.T_PROG_AE_CYC(24'd20), .T_PROG_CYC(24'd10), .T_PAGE_ER_CYC(24'd10),
    .T_FULL_ER_CYC(24'd40000), .T_HOLD_CYC(24'd50)) fcr_flash_ctrl_i (.*);
  fcr_master_model cpu_i (.core_clk_i, .ack_i(m0_ack_o), .abort_i(m0_abort_o),
    .rdata_i(bus_rdata_o), .req_o(m0_req_i), .we_o(m0_we_i), .flag_o(m0_dbg_i),
    .addr_o(m0_addr_i), .wdata_o(m0_wdata_i));
  fcr_master_model dma_i (.core_clk_i, .ack_i(m1_ack_o), .abort_i(m1_abort_o),
    .rdata_i(bus_rdata_o), .req_o(m1_req_i), .we_o(m1_we_i), .flag_o(m1_fpp_i),
    .addr_o(m1_addr_i), .wdata_o(m1_wdata_i));
  // 50 MHz clock
  always #10 core_clk_i = ~core_clk_i;
  // Hang guard, well above the full erase run
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      mismatches++;
      report_and_stop();
    end
  end
  // Case-equal word compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge core_clk_i);
    reg_we_i <= 1'b0;
  endtask
  // Register read; data stand from the following cycle until the next read
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge core_clk_i);
    reg_re_i <= 1'b0;
    #1 v = reg_rdata_o;
  endtask
  // Command write, then cycles spent busy; key defaults to the right one
  task automatic cmd(input logic [7:0] op, input logic [8:0] pg, output int c,
    input logic [7:0] k = `FCR_CMD_KEY);
    wr(`FCR_REG_CMD, {k, 7'h00, pg, op});
    c = 0;
    @(posedge core_clk_i);
    while (busy_o === 1'b1 && c < 50000)
    begin
      @(posedge core_clk_i);
      c++;
    end
  endtask
  // Boot alias, then remap
  task automatic t_map;
    cpu_i.xfer(q, ab, n, 32'h00200010, 1'b0, 0, 1'b1, 32'hA5A50001);
    cpu_i.xfer(q, ab, n, 32'h00200010);
    chk("sram", 32'hA5A50001, q);
    cmd(`FCR_OP_PAGE_ERASE, 9'd0, n);
    cpu_i.xfer(q, ab, n, 32'h00000040, 1'b0, 2);
    chk("alias", 32'hFFFFFFFF, q);
    wr(`FCR_REG_REMAP, 32'h1);
    cpu_i.xfer(q, ab, n, 32'h00000010);
    chk("remapped", 32'hA5A50001, q);
  endtask
  // Program, wait states and prefetch
  task automatic t_prog;
    cpu_i.xfer(q, ab, n, 32'h00100104, 1'b0, 0, 1'b1, 32'h12345678);
    wr(`FCR_REG_MODE, 32'h4);
    cmd(`FCR_OP_PROG, 9'd1, n);
    chk("prog busy", 32'h1, 32'(n >= 19));
    chk("done irq", 32'h1, 32'(irq_o));
    rd(`FCR_REG_STAT, d);
    chk("done", 32'h2, d & 32'h2);
    for (int w = 0; w < 4; w++)
    begin
      wr(`FCR_REG_MODE, w);
      dma_i.xfer(q, ab, n, 32'h00100080 + 32 * w, 1'b0, 6);
      chk("erased word", 32'hFFFFFFFF, q);
      chk("latency", 2 + w, n);
    end
    cpu_i.xfer(q, ab, n, 32'h001000E4, 1'b0, 6);
    chk("prefetch hit", 32'h2, n);
    dma_i.xfer(q, ab, n, 32'h00100104, 1'b0, 6);
    chk("programmed", 32'h12345678, q);
  endtask
  // Lock regions, key, busy refusal, NVM bits
  task automatic t_lock;
    wr(`FCR_REG_MODE, 32'h8);
    cmd(`FCR_OP_SET_LOCK, 9'd0, n);
    rd(`FCR_REG_STAT, d);
    chk("lock set", 32'h100, d & 32'hFF00);
    cmd(`FCR_OP_PROG, 9'd0, n);
    chk("locked run", 32'h0, n);
    chk("irq", 32'h1, 32'(irq_o));
    rd(`FCR_REG_STAT, d);
    chk("lock error", 32'h4, d & 32'h4);
    chk("irq clear", 32'h0, 32'(irq_o));
    cpu_i.xfer(q, ab, n, 32'h00100004);
    chk("kept word", 32'hFFFFFFFF, q);
    cmd(`FCR_OP_PAGE_ERASE, 9'd63, n);
    chk("page 63 run", 32'h0, n);
    rd(`FCR_REG_STAT, d);
    rd(`FCR_REG_CMD, d);
    wr(`FCR_REG_CMD, {`FCR_CMD_KEY, 7'h00, 9'd64, `FCR_OP_PAGE_ERASE});
    cmd(`FCR_OP_SET_LOCK, 9'd128, n);
    cmd(`FCR_OP_SET_LOCK, 9'd64, n, 8'hA5);
    rd(`FCR_REG_STAT, d);
    chk("page 64 ok", 32'h0, d & 32'h4);
    chk("busy refusal", 32'h100, d & 32'hFF00);
    cmd(`FCR_OP_CLR_LOCK, 9'd0, n);
    cmd(`FCR_OP_SET_NVM, 9'd1, n);
    rd(`FCR_REG_STAT, d);
    chk("nvm set", 32'h20, d & 32'hFF30);
    cmd(`FCR_OP_CLR_NVM, 9'd1, n);
    cmd(`FCR_OP_SET_LOCK, 9'd448, n);
    rd(`FCR_REG_STAT, d);
    chk("nvm clear", 32'h8000, d & 32'hFF30);
  endtask
  // Security, holes, erase pin and full erase
  task automatic t_sec;
    cmd(`FCR_OP_SET_SEC, 9'd0, n);
    cpu_i.xfer(q, ab, n, 32'h00100000, 1'b1);
    chk("debug abort", 32'h1, 32'(ab));
    dma_i.xfer(q, ab, n, 32'h00100104, 1'b1);
    chk("fpp abort", 32'h1, 32'(ab));
    cpu_i.xfer(q, ab, n, 32'h00200010, 1'b1);
    chk("sram open", 32'h0, 32'(ab));
    cpu_i.xfer(q, ab, n, 32'h0FFFFFFC);
    chk("hole", 32'h1, 32'(ab));
    erase_pin_i <= 1'b1;
    repeat (60) @(posedge core_clk_i); // Held past the hold time
    rd(`FCR_REG_STAT, d);
    chk("pin unlock", 32'h8, d & 32'hFF08);
    cmd(`FCR_OP_FULL_ERASE, 9'd0, n);
    chk("erase busy", 32'h1, 32'(n >= 39999));
    erase_pin_i <= 1'b0;
    rd(`FCR_REG_STAT, d);
    chk("unsecured", 32'h0, d & 32'h8);
    cpu_i.xfer(q, ab, n, 32'h00100104, 1'b1);
    chk("open read", 32'hFFFFFFFF, q);
  endtask
  // Counts and verdict
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Reset, then the scenarios in order
  initial
  begin
    repeat (20) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    t_map();
    t_prog();
    t_lock();
    t_sec();
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire

// ### hw/fcr_busy_timer.v
// Down counter that holds the busy time of a flash command
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.vh"
module fcr_busy_timer #(
  parameter W = `FCR_TMR_W
) (
  input  wire         core_clk_i,
  input  wire         resetn_i,
  input  wire         load_i,
  input  wire [W-1:0] count_i,
  output wire         busy_o
);
  reg [W-1:0] remain;                        // Cycles still to run

  // Load on command start, then count down to zero
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      remain <= {W{1'b0}};
    else if (load_i)
      remain <= count_i;
    else if (remain != {W{1'b0}})
      remain <= remain - {{(W-1){1'b0}}, 1'b1};
  end

  assign busy_o = (remain != {W{1'b0}});     // Busy while time remains
endmodule // fcr_busy_timer
`default_nettype wire

// ### hw/fcr_flash_ctrl.v
// Flash controller with boot alias, remap, prefetch, write buffer and command sequencer
// What this block does
// RULE1: SRAM at 0x00200000, also at zero after remap
// RULE2: Flash at 0x00100000, aliased at zero before remap
// RULE3: Flash array read as 32768 32-bit words
// RULE4: 256-byte page write buffer, 32-bit writes
// RULE5: Arbitrate masters; read flash, write buffer
// RULE6: Software wait states steer flash read timing
// RULE7: Wait-state setting allows up to three
// RULE8: Execute full, page erase, program, NVM commands
// RULE9: Done and error status, each enableable interrupt
// RULE10: Two 32-bit prefetch buffers for sequential fetches
// RULE11: Eight lock bits, 64 pages each
// RULE12: Locked erase or program aborts, raises error
// RULE13: Set-lock protects region, clear-lock unprotects it
// RULE14: Erase pin clears all lock bits
// RULE15: Secure bit refuses debug and fast-programming access
// RULE16: Security set by command, cleared by erase
// RULE17: Erase pin must be held over 50 ms
// RULE18: Busy 4 ms, 2 ms, 10 ms per command
// RULE19: Zero wait states give single-cycle reads
// RULE20: Commands without matching key are ignored
// RULE21: Addresses from 0x00300000 upward abort
// RULE22: Busy while executing, no second command
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "fcr_defines.vh"
module fcr_flash_ctrl #(
  parameter                 SRAM_AW       = 13,
  parameter [`FCR_TMR_W-1:0] T_PROG_AE_CYC = `FCR_T_PROG_AE_US * `FCR_CLK_MHZ,
  parameter [`FCR_TMR_W-1:0] T_PROG_CYC    = `FCR_T_PROG_US * `FCR_CLK_MHZ,
  parameter [`FCR_TMR_W-1:0] T_PAGE_ER_CYC = `FCR_T_PAGE_ER_US * `FCR_CLK_MHZ,
  parameter [`FCR_TMR_W-1:0] T_FULL_ER_CYC = `FCR_T_FULL_ER_US * `FCR_CLK_MHZ,
  parameter [`FCR_TMR_W-1:0] T_HOLD_CYC    = `FCR_T_ERASE_HOLD_US * `FCR_CLK_MHZ
) (
  input  wire        core_clk_i,
  input  wire        resetn_i,
  input  wire        m0_req_i,
  input  wire        m0_we_i,
  input  wire        m0_dbg_i,
  input  wire [31:0] m0_addr_i,
  input  wire [31:0] m0_wdata_i,
  output wire        m0_ack_o,
  output wire        m0_abort_o,
  input  wire        m1_req_i,
  input  wire        m1_we_i,
  input  wire        m1_fpp_i,
  input  wire [31:0] m1_addr_i,
  input  wire [31:0] m1_wdata_i,
  output wire        m1_ack_o,
  output wire        m1_abort_o,
  output reg  [31:0] bus_rdata_o,
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_we_i,
  input  wire        reg_re_i,
  output reg  [31:0] reg_rdata_o,
  input  wire        erase_pin_i,
  output wire        irq_o,
  output wire        busy_o
);
  localparam [1:0] ST_IDLE = 2'd0;           // Waiting for a bus request
  localparam [1:0] ST_WAIT = 2'd1;           // Counting flash wait states
  localparam [1:0] ST_ACK  = 2'd2;           // Answer cycle
  localparam [1:0] ST_PF   = 2'd3;           // Fetching the next word ahead
  localparam [`FCR_TMR_W-1:0] T_NVM_CYC = `FCR_T_NVM_US * `FCR_CLK_MHZ;

  reg [31:0] flash_mem [0:32767];            // Array as 32768 words [RULE3]
  reg [31:0] sram_mem  [0:(1<<SRAM_AW)-1];   // SRAM words
  reg [31:0] wbuf      [0:63];               // Page write buffer

  reg [1:0]  state;                          // Bus state
  reg        sel;                            // Master being served
  reg        rr_last;                        // Last master granted
  reg        abort_r;                        // Answer is an abort
  reg        pf_go;                          // Fetch ahead after answer
  reg [1:0]  ws_cnt;                         // Wait states left
  reg [14:0] lat_idx;                        // Latched flash word index
  reg [14:0] pf_tag0;                        // Word held in buffer 0
  reg [14:0] pf_tag1;                        // Word held in buffer 1
  reg        pf_v0;                          // Buffer 0 valid
  reg        pf_v1;                          // Buffer 1 valid
  reg [31:0] pf_d0;                          // Buffer 0 data
  reg [31:0] pf_d1;                          // Buffer 1 data
  reg [4:0]  mode;                           // Wait states, enables, no auto-erase
  reg        remap;                          // Remap done
  reg        run;                            // Command executing
  reg [7:0]  op;                             // Command being executed
  reg [8:0]  op_page;                        // Target page
  reg [14:0] walk_cnt;                       // Array word being rewritten
  reg        walk_on;                        // Array rewrite in progress
  reg        done_f;                         // Sticky command done
  reg        lerr_f;                         // Sticky lock error
  reg [7:0]  lock;                           // Region lock bits
  reg        sec;                            // Security bit
  reg [1:0]  nvm;                            // General NVM bits
  reg        er_s1;                          // Erase pin sync stage 1
  reg        er_s2;                          // Erase pin sync stage 2
  reg [`FCR_TMR_W-1:0] hold_cnt;             // Erase pin hold time
  reg        erase_act;                      // Erase pin held long enough

  wire        pick = m1_req_i & (~m0_req_i | ~rr_last);   // Round robin choice [RULE5]
  wire        any_req = m0_req_i | m1_req_i;
  wire [31:0] r_addr  = pick ? m1_addr_i : m0_addr_i;
  wire [31:0] r_wdata = pick ? m1_wdata_i : m0_wdata_i;
  wire        r_we    = pick ? m1_we_i : m0_we_i;
  wire        r_restr = pick ? m1_fpp_i : m0_dbg_i;
  wire [11:0] r_mb    = r_addr[31:20];
  wire        r_alias = (r_mb == `FCR_MAP_ALIAS);
  wire        r_flash = (r_mb == `FCR_MAP_FLASH) | (r_alias & ~remap);  // [RULE2]
  wire        r_sram  = (r_mb == `FCR_MAP_SRAM) | (r_alias & remap);    // [RULE1]
  wire        r_deny  = r_flash & sec & r_restr;     // Secure flash refused [RULE15]
  wire        r_bad   = ~(r_flash | r_sram);         // Undefined area [RULE21]
  wire [14:0] r_idx   = r_addr[16:2];
  wire        hit0    = pf_v0 & (pf_tag0 == r_idx);
  wire        hit1    = pf_v1 & (pf_tag1 == r_idx);
  wire [1:0]  ws      = mode[`FCR_MODE_WS_LSB+1:`FCR_MODE_WS_LSB];  // 0..3 [RULE7]
  wire        tmr_busy;
  wire        finish  = run & ~tmr_busy & ~walk_on;

  assign m0_ack_o   = (state == ST_ACK) & ~sel;
  assign m1_ack_o   = (state == ST_ACK) & sel;
  assign m0_abort_o = m0_ack_o & abort_r;
  assign m1_abort_o = m1_ack_o & abort_r;
  assign busy_o     = run;                   // [RULE22]
  assign irq_o = (done_f & mode[`FCR_MODE_DONE_IE]) |
                 (lerr_f & mode[`FCR_MODE_ERR_IE]);  // [RULE9]

  // Bus sequencer; flash reads that miss both prefetch buffers wait for the array while a command runs
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state       <= ST_IDLE;
      sel         <= 1'b0;
      rr_last     <= 1'b0;
      abort_r     <= 1'b0;
      pf_go       <= 1'b0;
      ws_cnt      <= 2'h0;
      lat_idx     <= 15'h0;
      pf_tag0     <= 15'h0;
      pf_tag1     <= 15'h0;
      pf_v0       <= 1'b0;
      pf_v1       <= 1'b0;
      pf_d0       <= 32'h0;
      pf_d1       <= 32'h0;
      bus_rdata_o <= 32'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (any_req)
          begin
            sel     <= pick;
            rr_last <= pick;
            abort_r <= r_bad | r_deny;
            pf_go   <= 1'b0;
            lat_idx <= r_idx;
            if (r_bad | r_deny | r_sram | r_we)
              state <= ST_ACK;               // One-cycle answer
            else if (hit0)
            begin
              bus_rdata_o <= pf_d0;          // Same word again [RULE10]
              state       <= ST_ACK;
            end
            else if (hit1)
            begin
              // Next word ready; shift it down and fetch further ahead
              bus_rdata_o <= pf_d1;
              pf_d0       <= pf_d1;
              pf_tag0     <= pf_tag1;
              pf_v0       <= 1'b1;
              pf_v1       <= 1'b0;
              pf_go       <= 1'b1;
              state       <= ST_ACK;         // [RULE10]
            end
            else if (!run)
            begin
              if (ws == 2'h0)
              begin
                bus_rdata_o <= flash_mem[r_idx];  // No wait state [RULE19]
                pf_d0       <= flash_mem[r_idx];
                pf_tag0     <= r_idx;
                pf_v0       <= 1'b1;
                pf_v1       <= 1'b0;
                pf_go       <= 1'b1;
                state       <= ST_ACK;
              end
              else
              begin
                ws_cnt <= ws - 2'h1;         // [RULE6]
                state  <= ST_WAIT;
              end
            end
            if (r_sram & ~r_bad & ~r_we)
              bus_rdata_o <= sram_mem[r_addr[SRAM_AW+1:2]];
          end
        end
        ST_WAIT:
        begin
          if (ws_cnt != 2'h0)
            ws_cnt <= ws_cnt - 2'h1;         // [RULE6]
          else
          begin
            bus_rdata_o <= flash_mem[lat_idx];
            pf_d0       <= flash_mem[lat_idx];
            pf_tag0     <= lat_idx;
            pf_v0       <= 1'b1;
            pf_v1       <= 1'b0;
            pf_go       <= 1'b1;
            state       <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          ws_cnt <= ws;
          state  <= (pf_go & ~run) ? ST_PF : ST_IDLE;
        end
        default:
        begin
          // Fetch ahead costs the same wait states as a demand read
          if (run)
            state <= ST_IDLE;
          else if (ws_cnt != 2'h0)
            ws_cnt <= ws_cnt - 2'h1;
          else
          begin
            pf_d1   <= flash_mem[pf_tag0 + 15'h1];
            pf_tag1 <= pf_tag0 + 15'h1;
            pf_v1   <= 1'b1;             // [RULE10]
            state   <= ST_IDLE;
          end
        end
      endcase
      // Array changed; stale words go, but an answer in flight still ends
      if (finish)
      begin
        pf_v0 <= 1'b0;
        pf_v1 <= 1'b0;
      end
    end
  end

  // SRAM and write buffer stores, taken in the idle cycle of the request
  always @(posedge core_clk_i)
  begin
    if (state == ST_IDLE && any_req && r_we && !r_bad && !r_deny)
    begin
      if (r_sram)
        sram_mem[r_addr[SRAM_AW+1:2]] <= r_wdata;
      else
        wbuf[r_addr[7:2]] <= r_wdata;        // 32-bit buffer write [RULE4]
    end
  end

  // Array rewrite, one word a cycle while a command runs
  always @(posedge core_clk_i)
  begin
    if (walk_on)
    begin
      if (op == `FCR_OP_FULL_ERASE)
        flash_mem[walk_cnt] <= 32'hFFFFFFFF;
      else if (op == `FCR_OP_PAGE_ERASE)
        flash_mem[{op_page, walk_cnt[5:0]}] <= 32'hFFFFFFFF;
      else if (mode[`FCR_MODE_NOAE])
        flash_mem[{op_page, walk_cnt[5:0]}] <=
          flash_mem[{op_page, walk_cnt[5:0]}] & wbuf[walk_cnt[5:0]];
      else
        flash_mem[{op_page, walk_cnt[5:0]}] <= wbuf[walk_cnt[5:0]];
    end
  end

  // Erase pin: synchronise, then qualify by hold time
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      er_s1     <= 1'b0;
      er_s2     <= 1'b0;
      hold_cnt  <= {`FCR_TMR_W{1'b0}};
      erase_act <= 1'b0;
    end
    else
    begin
      er_s1 <= erase_pin_i;
      er_s2 <= er_s1;
      if (!er_s2)
      begin
        hold_cnt  <= {`FCR_TMR_W{1'b0}};
        erase_act <= 1'b0;
      end
      else if (hold_cnt >= T_HOLD_CYC)
        erase_act <= 1'b1;                   // Short glitches ignored [RULE17]
      else
        hold_cnt <= hold_cnt + {{(`FCR_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  // Command decode: key, busy and lock checks
  wire [7:0] c_op   = reg_wdata_i[7:0];
  wire [8:0] c_page = reg_wdata_i[`FCR_CMD_PAGE_LSB+8:`FCR_CMD_PAGE_LSB];
  wire [2:0] c_reg  = c_page[8:6];           // 64 pages per region [RULE11]
  wire c_key  = (reg_wdata_i[`FCR_CMD_KEY_LSB+7:`FCR_CMD_KEY_LSB] == `FCR_CMD_KEY);
  wire c_page_op = (c_op == `FCR_OP_PROG) | (c_op == `FCR_OP_PAGE_ERASE);
  wire c_known = c_page_op | (c_op == `FCR_OP_FULL_ERASE) |
                 (c_op == `FCR_OP_SET_LOCK) | (c_op == `FCR_OP_CLR_LOCK) |
                 (c_op == `FCR_OP_SET_NVM) | (c_op == `FCR_OP_CLR_NVM) |
                 (c_op == `FCR_OP_SET_SEC);
  wire c_write = reg_we_i & (reg_addr_i == `FCR_REG_CMD);
  wire c_take  = c_write & c_key & c_known & ~run;  // [RULE20] [RULE22]
  wire c_locked = (c_page_op & lock[c_reg]) |
                  ((c_op == `FCR_OP_FULL_ERASE) & (|lock));  // [RULE11]
  wire c_start = c_take & ~c_locked;
  wire st_read = reg_re_i & (reg_addr_i == `FCR_REG_STAT);
  reg [`FCR_TMR_W-1:0] next_time;            // Busy time of the new command

  // Busy time per command
  always @*
  begin
    next_time = T_NVM_CYC;
    if (c_op == `FCR_OP_PROG)
      next_time = mode[`FCR_MODE_NOAE] ? T_PROG_CYC : T_PROG_AE_CYC;  // [RULE18]
    else if (c_op == `FCR_OP_PAGE_ERASE)
      next_time = T_PAGE_ER_CYC;
    else if (c_op == `FCR_OP_FULL_ERASE)
      next_time = T_FULL_ER_CYC;             // [RULE18]
  end

  fcr_busy_timer #(
    .W          (`FCR_TMR_W)
  ) u_timer (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .load_i     (c_start),
    .count_i    (next_time),
    .busy_o     (tmr_busy)
  );

  // Command sequencer, status flags and non-volatile bits
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      run      <= 1'b0;
      op       <= 8'h00;
      op_page  <= 9'h000;
      walk_cnt <= 15'h0;
      walk_on  <= 1'b0;
      done_f   <= 1'b0;
      lerr_f   <= 1'b0;
      lock     <= 8'h00;
      sec      <= 1'b0;
      nvm      <= 2'h0;
      mode     <= `FCR_MODE_RST;
      remap    <= 1'b0;
    end
    else
    begin
      if (reg_we_i && reg_addr_i == `FCR_REG_MODE)
        mode <= reg_wdata_i[4:0];            // [RULE6]
      if (reg_we_i && reg_addr_i == `FCR_REG_REMAP && reg_wdata_i[0])
        remap <= 1'b1;                       // Remap is one-way until reset [RULE1]
      // Set wins over the clear by a status read
      done_f <= finish | (done_f & ~st_read);  // [RULE9]
      lerr_f <= (c_take & c_locked) | (lerr_f & ~st_read);  // [RULE12]
      if (c_start)
      begin
        run      <= 1'b1;                    // [RULE8]
        op       <= c_op;
        op_page  <= c_page;
        walk_cnt <= 15'h0;
        walk_on  <= c_page_op | (c_op == `FCR_OP_FULL_ERASE);
      end
      else if (walk_on)
      begin
        walk_cnt <= walk_cnt + 15'h1;
        if ((op == `FCR_OP_FULL_ERASE) ? (walk_cnt == 15'h7FFF) : (walk_cnt == 15'h003F))
          walk_on <= 1'b0;
      end
      if (finish)
      begin
        run <= 1'b0;
        if (op == `FCR_OP_SET_LOCK)
          lock[op_page[8:6]] <= 1'b1;        // [RULE13]
        if (op == `FCR_OP_CLR_LOCK)
          lock[op_page[8:6]] <= 1'b0;        // [RULE13]
        if (op == `FCR_OP_SET_NVM)
          nvm[op_page[0]] <= 1'b1;           // [RULE8]
        if (op == `FCR_OP_CLR_NVM)
          nvm[op_page[0]] <= 1'b0;
        if (op == `FCR_OP_SET_SEC)
          sec <= 1'b1;                       // Only way to set it [RULE16]
        if (op == `FCR_OP_FULL_ERASE && erase_act)
          sec <= 1'b0;                       // [RULE16]
      end
      if (erase_act)
        lock <= 8'h00;                       // [RULE14]
    end
  end

  // Register read data, one cycle after the strobe
  always @(posedge core_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      reg_rdata_o <= 32'h0;
    else if (reg_re_i)
    begin
      if (reg_addr_i == `FCR_REG_MODE)
        reg_rdata_o <= {27'h0, mode};
      else if (reg_addr_i == `FCR_REG_STAT)
        reg_rdata_o <= {16'h0, lock, 2'h0, nvm, sec, lerr_f, done_f, run};  // [RULE9]
      else if (reg_addr_i == `FCR_REG_REMAP)
        reg_rdata_o <= {31'h0, remap};
      else
        reg_rdata_o <= 32'h0;
    end
  end
endmodule // fcr_flash_ctrl
`default_nettype wire

// ### pkg/fcr_defines.vh
// Shared offsets, fields, codes and timing constants of the flash controller
`ifndef FCR_DEFINES_VH
`define FCR_DEFINES_VH
// Register offsets on the plain register port
`define FCR_REG_MODE       8'h00
`define FCR_REG_CMD        8'h04
`define FCR_REG_STAT       8'h08
`define FCR_REG_REMAP      8'h0C
// Address map, bits [31:20] of a bus address
`define FCR_MAP_ALIAS      12'h000
`define FCR_MAP_FLASH      12'h001
`define FCR_MAP_SRAM       12'h002
// Mode register fields
`define FCR_MODE_WS_LSB    0
`define FCR_MODE_DONE_IE   2
`define FCR_MODE_ERR_IE    3
`define FCR_MODE_NOAE      4
`define FCR_MODE_RST       5'h00
// Command register fields
`define FCR_CMD_PAGE_LSB   8
`define FCR_CMD_KEY_LSB    24
`define FCR_CMD_KEY        8'h5A
// Command codes
`define FCR_OP_PROG        8'h01
`define FCR_OP_SET_LOCK    8'h02
`define FCR_OP_PAGE_ERASE  8'h03
`define FCR_OP_CLR_LOCK    8'h04
`define FCR_OP_FULL_ERASE  8'h08
`define FCR_OP_SET_NVM     8'h0B
`define FCR_OP_CLR_NVM     8'h0D
`define FCR_OP_SET_SEC     8'h0F
// Status register bit positions
`define FCR_ST_BUSY        0
`define FCR_ST_DONE        1
`define FCR_ST_LOCKERR     2
`define FCR_ST_SEC         3
`define FCR_ST_NVM_LSB     4
`define FCR_ST_LOCK_LSB    8
// Timing, in the printed units
`define FCR_CLK_MHZ        50
`define FCR_T_PROG_AE_US   4000
`define FCR_T_PROG_US      2000
`define FCR_T_PAGE_ER_US   2000
`define FCR_T_FULL_ER_US   10000
`define FCR_T_NVM_US       1
`define FCR_T_ERASE_HOLD_US 50000
// Timer width, wide enough for the longest count
`define FCR_TMR_W          24
`endif
